// >>> src/port_k_ctrl.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// three-pin general-purpose port: registers, function muxing and pads
module port_k_ctrl (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic timer_nine_output_i,
  input wire logic system_clock_output_i,
  input wire logic alarm_output_i,
  input wire logic fn_pin0_out_i,
  input wire logic fn_pin0_oe_i,
  input wire logic [2:0] pad_in_i,
  output logic [2:0] pad_out_o,
  output logic [2:0] pad_oe_o,
  output logic [2:0] pad_pullup_o,
  output logic [2:0] core_in_o
);

  // register state
  logic [2:0] pin_data_q;
  logic [2:0] pin_data_d;
  logic [2:0] output_enable_bits_q;
  logic [2:0] output_enable_bits_d;
  logic [2:0] fn_one_q;
  logic [2:0] fn_one_d;
  logic [2:0] fn_two_q;
  logic [2:0] fn_two_d;
  logic [2:0] pullup_enable_bits_q;
  logic [2:0] pullup_enable_bits_d;
  logic [2:0] input_enable_bits_q;
  logic [2:0] input_enable_bits_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // reset-window flag and sampled pad levels
  logic in_reset_q;
  logic [2:0] pad_in_q;

  // pad-side registered outputs
  logic [2:0] pad_out_q;
  logic [2:0] pad_oe_q;
  logic [2:0] pad_pullup_q;
  logic [2:0] core_in_q;

  // combinational outputs of the pin cells
  logic [2:0] cell_out;
  logic [2:0] cell_oe;
  logic [2:0] cell_pull;
  logic [2:0] cell_in;

  // merge masked write data into a register's current value
  function automatic logic [2:0] masked_write(
    input logic [2:0] cur,
    input logic [31:0] data,
    input logic [2:0] mask
  );
    masked_write = (cur & ~mask) | (data[2:0] & mask);
  endfunction

  // widen a three-bit field to a bus word, upper bits zero
  function automatic logic [31:0] to_word(input logic [2:0] val);
    to_word = {29'h0, val};
  endfunction

  // address decode
  wire hit_data = (addr_i == port_k_pkg::pin_data_reg_off);
  wire hit_cr = (addr_i == port_k_pkg::output_control_reg_off);
  wire hit_fn1 = (addr_i == port_k_pkg::fn_select_one_off);
  wire hit_fn2 = (addr_i == port_k_pkg::fn_select_two_off);
  wire hit_pup = (addr_i == port_k_pkg::pullup_enable_off);
  wire hit_ie = (addr_i == port_k_pkg::input_enable_off);

  // write strobes per register
  wire wr_data = wr_i & hit_data;
  wire wr_cr = wr_i & hit_cr;
  wire wr_fn1 = wr_i & hit_fn1;
  wire wr_fn2 = wr_i & hit_fn2;
  wire wr_pup = wr_i & hit_pup;
  wire wr_ie = wr_i & hit_ie;

  // next values: only writable bits take write data
  assign pin_data_d = wr_data ?
    masked_write(pin_data_q, wdata_i, port_k_pkg::pin_data_mask) :
    pin_data_q;
  assign output_enable_bits_d = wr_cr ?
    masked_write(output_enable_bits_q, wdata_i,
                 port_k_pkg::output_enable_mask) :
    output_enable_bits_q;
  assign fn_one_d = wr_fn1 ?
    masked_write(fn_one_q, wdata_i, port_k_pkg::fn_one_mask) :
    fn_one_q;
  assign fn_two_d = wr_fn2 ?
    masked_write(fn_two_q, wdata_i, port_k_pkg::fn_two_mask) :
    fn_two_q;
  assign pullup_enable_bits_d = wr_pup ?
    masked_write(pullup_enable_bits_q, wdata_i,
                 port_k_pkg::pullup_mask) :
    pullup_enable_bits_q;
  assign input_enable_bits_d = wr_ie ?
    masked_write(input_enable_bits_q, wdata_i,
                 port_k_pkg::input_enable_mask) :
    input_enable_bits_q;

  // data readback: driven pins show the latch, enabled inputs the pad
  wire [2:0] data_view =
    (pin_data_q & output_enable_bits_q) |
    (pad_in_q & input_enable_bits_q & ~output_enable_bits_q);

  // read mux; unmapped addresses and upper bits read zero
  wire [31:0] sel_data = hit_data ? to_word(data_view) : 32'h0000_0000;
  wire [31:0] sel_cr = hit_cr ?
    to_word(output_enable_bits_q) : 32'h0000_0000;
  wire [31:0] sel_fn1 = hit_fn1 ? to_word(fn_one_q) : 32'h0000_0000;
  wire [31:0] sel_fn2 = hit_fn2 ? to_word(fn_two_q) : 32'h0000_0000;
  wire [31:0] sel_pup = hit_pup ?
    to_word(pullup_enable_bits_q) : 32'h0000_0000;
  wire [31:0] sel_ie = hit_ie ?
    to_word(input_enable_bits_q) : 32'h0000_0000;
  wire [31:0] read_word =
    sel_data | sel_cr | sel_fn1 | sel_fn2 | sel_pup | sel_ie;

  // read data stands only in the cycle after the strobe
  assign rdata_d = rd_i ? read_word : 32'h0000_0000;

  // port data latch; cleared so that enabling a driver after reset
  // puts a low on the pin, never a stale high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_data_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      pin_data_q <= pin_data_d;
    end
  end

  // output enables; a cleared bit leaves the pin undriven unless pin 0's function is selected, so reset
  // can never push a level onto the board
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_enable_bits_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      output_enable_bits_q <= output_enable_bits_d;
    end
  end

  // first function selects; pin 0's bit is stored although selecting
  // it is reserved, so software reads back what it wrote and the pin
  // keeps a defined open-drain path either way
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fn_one_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      fn_one_q <= fn_one_d;
    end
  end

  // second function selects; only the alarm bit for pin 1 is stored,
  // the mask keeps the other bits at zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fn_two_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      fn_two_q <= fn_two_d;
    end
  end

  // pull-up enables; pin 0 has no pull resistor, so its bit never
  // leaves zero and a stray write cannot make the open-drain pin
  // float high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pullup_enable_bits_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      pullup_enable_bits_q <= pullup_enable_bits_d;
    end
  end

  // input enables; cleared at reset so a floating pin cannot feed
  // random levels into the core before software has set the port up;
  // the cost is that no pad level can be read until software enables it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      input_enable_bits_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      input_enable_bits_q <= input_enable_bits_d;
    end
  end

  // bus read register; zero outside the read slot so a stale word
  // can never be mistaken for an answer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= port_k_pkg::reg_reset_value;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // high while reset is held and for the first edge after release;
  // the async set means the pull gate acts even with no clock running
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= 1'b0;
    end
  end

  // pads are taken as synchronous; one register keeps paths short,
  // at the price of one cycle of input latency
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_in_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      pad_in_q <= pad_in_i;
    end
  end

  // per-pin function selects taken out of the select registers
  wire pick_fn_pin0 = fn_one_q[port_k_pkg::fn_one_sel_pin0];
  wire pick_sysclk_pin1 = fn_one_q[port_k_pkg::fn_one_sel_pin1];
  wire pick_alarm_pin1 = fn_two_q[port_k_pkg::fn_two_sel_pin1];
  wire pick_timer_pin2 = fn_one_q[port_k_pkg::fn_one_sel_pin2];

  // pin 0: open-drain cell, function selection is reserved but wired
  port_k_pin_cell #(
    .cell_kind(port_k_pkg::open_drain_type),
    .pull_reset_forced(1'b1)
  ) u_pin0 (
    .port_data_i(pin_data_q[0]),
    .out_en_i(output_enable_bits_q[0]),
    .fn1_sel_i(pick_fn_pin0),
    .fn1_val_i(fn_pin0_out_i),
    .fn1_oe_i(fn_pin0_oe_i),
    .fn2_sel_i(1'b0),
    .fn2_val_i(1'b0),
    .pull_en_i(pullup_enable_bits_q[0]),
    .in_en_i(input_enable_bits_q[0]),
    .in_reset_i(in_reset_q),
    .pad_in_i(pad_in_q[0]),
    .pad_out_o(cell_out[0]),
    .pad_oe_o(cell_oe[0]),
    .pad_pull_o(cell_pull[0]),
    .core_in_o(cell_in[0])
  );

  // pin 1: dual-output cell, system clock or alarm
  port_k_pin_cell #(
    .cell_kind(port_k_pkg::dual_output_fn_type),
    .pull_reset_forced(1'b1)
  ) u_pin1 (
    .port_data_i(pin_data_q[1]),
    .out_en_i(output_enable_bits_q[1]),
    .fn1_sel_i(pick_sysclk_pin1),
    .fn1_val_i(system_clock_output_i),
    .fn1_oe_i(1'b0),
    .fn2_sel_i(pick_alarm_pin1),
    .fn2_val_i(alarm_output_i),
    .pull_en_i(pullup_enable_bits_q[1]),
    .in_en_i(input_enable_bits_q[1]),
    .in_reset_i(in_reset_q),
    .pad_in_i(pad_in_q[1]),
    .pad_out_o(cell_out[1]),
    .pad_oe_o(cell_oe[1]),
    .pad_pull_o(cell_pull[1]),
    .core_in_o(cell_in[1])
  );

  // pin 2: single-output cell, timer nine
  port_k_pin_cell #(
    .cell_kind(port_k_pkg::single_output_fn_type),
    .pull_reset_forced(1'b1)
  ) u_pin2 (
    .port_data_i(pin_data_q[2]),
    .out_en_i(output_enable_bits_q[2]),
    .fn1_sel_i(pick_timer_pin2),
    .fn1_val_i(timer_nine_output_i),
    .fn1_oe_i(1'b0),
    .fn2_sel_i(1'b0),
    .fn2_val_i(1'b0),
    .pull_en_i(pullup_enable_bits_q[2]),
    .in_en_i(input_enable_bits_q[2]),
    .in_reset_i(in_reset_q),
    .pad_in_i(pad_in_q[2]),
    .pad_out_o(cell_out[2]),
    .pad_oe_o(cell_oe[2]),
    .pad_pull_o(cell_pull[2]),
    .core_in_o(cell_in[2])
  );

  // pad drive values; registered so the pins never see decode glitches
  // while a select bit and the port latch change in one cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_out_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      pad_out_q <= cell_out;
    end
  end

  // pad drive enables; cleared asynchronously so no pin is driven
  // while reset is held, even with the clock stopped
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_oe_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      pad_oe_q <= cell_oe;
    end
  end

  // pull-up enables; cleared asynchronously so the pull is off for the
  // whole reset, not only after a clock edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_pullup_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      pad_pullup_q <= cell_pull;
    end
  end

  // gated inputs to the core; second stage after the pad sample, so
  // the core sees a level two edges after the pin settles
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_in_q <= port_k_pkg::reg_reset_value[2:0];
    end else begin
      core_in_q <= cell_in;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o = rdata_q;
  assign pad_out_o = pad_out_q;
  assign pad_oe_o = pad_oe_q;
  assign pad_pullup_o = pad_pullup_q;
  assign core_in_o = core_in_q;

endmodule

// >>> src/port_k_pin_cell.sv
`timescale 1ns/1ps
// one pin's output mux, driver control, pull control and input gate
module port_k_pin_cell #(
  parameter port_k_pkg::pin_cell_type cell_kind =
    port_k_pkg::single_output_fn_type,
  parameter bit pull_reset_forced = 1'b1
) (
  input wire logic port_data_i,
  input wire logic out_en_i,
  input wire logic fn1_sel_i,
  input wire logic fn1_val_i,
  input wire logic fn1_oe_i,
  input wire logic fn2_sel_i,
  input wire logic fn2_val_i,
  input wire logic pull_en_i,
  input wire logic in_en_i,
  input wire logic in_reset_i,
  input wire logic pad_in_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic pad_pull_o,
  output logic core_in_o
);

  logic drive_val;
  logic drive_en;

  // output source: second function beats first, first beats port
  always_comb begin
    drive_val = port_data_i;
    drive_en = out_en_i;
    case (cell_kind)
      port_k_pkg::open_drain_type: begin
        if (fn1_sel_i) begin
          drive_val = fn1_val_i;
          drive_en = fn1_oe_i;
        end
      end
      port_k_pkg::dual_output_fn_type: begin
        if (fn2_sel_i) begin
          drive_val = fn2_val_i;
        end else if (fn1_sel_i) begin
          drive_val = fn1_val_i;
        end
      end
      port_k_pkg::single_output_fn_type: begin
        if (fn1_sel_i) begin
          drive_val = fn1_val_i;
        end
      end
      default: begin
        drive_en = 1'b0;
      end
    endcase
  end

  // open drain only ever pulls low; a high releases the pad
  always_comb begin
    if (cell_kind == port_k_pkg::open_drain_type) begin
      pad_out_o = 1'b0;
      pad_oe_o = drive_en & ~drive_val;
      pad_pull_o = 1'b0; // no pull resistor on this cell
    end else begin
      pad_out_o = drive_val;
      pad_oe_o = drive_en;
      if (pull_reset_forced) begin
        pad_pull_o = pull_en_i & ~in_reset_i;
      end else begin
        pad_pull_o = pull_en_i;
      end
    end
  end

  // input path is gated off unless enabled
  assign core_in_o = pad_in_i & in_en_i;

endmodule

// >>> src/port_k_pkg.sv
package port_k_pkg;

  localparam int unsigned pin_count = 3;
  localparam int unsigned addr_width = 8;

  // register byte offsets from the port base
  localparam logic [7:0] pin_data_reg_off = 8'h00;
  localparam logic [7:0] output_control_reg_off = 8'h04;
  localparam logic [7:0] fn_select_one_off = 8'h08;
  localparam logic [7:0] fn_select_two_off = 8'h0c;
  localparam logic [7:0] pullup_enable_off = 8'h2c;
  localparam logic [7:0] input_enable_off = 8'h38;

  // value after reset of every control register
  localparam logic [31:0] reg_reset_value = 32'h0000_0000;

  // writable bit masks; every other bit is read-only zero
  localparam logic [2:0] pin_data_mask = 3'h7;
  localparam logic [2:0] output_enable_mask = 3'h7;
  localparam logic [2:0] fn_one_mask = 3'h7;
  localparam logic [2:0] fn_two_mask = 3'h2;
  localparam logic [2:0] pullup_mask = 3'h6;
  localparam logic [2:0] input_enable_mask = 3'h7;

  // field positions
  localparam int unsigned fn_one_sel_pin0 = 0;
  localparam int unsigned fn_one_sel_pin1 = 1;
  localparam int unsigned fn_one_sel_pin2 = 2;
  localparam int unsigned fn_two_sel_pin1 = 1;

  // pin circuit kinds
  typedef enum logic [1:0] {
    open_drain_type = 2'b00,
    dual_output_fn_type = 2'b01,
    single_output_fn_type = 2'b10
  } pin_cell_type;

endpackage

// >>> verif/port_k_checker.sv
`timescale 1ns/1ps
// pins judged against shadow copies of accepted register writes
module port_k_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic timer_nine_output_i,
  input wire logic system_clock_output_i,
  input wire logic alarm_output_i,
  input wire logic fn_pin0_out_i,
  input wire logic fn_pin0_oe_i,
  input wire logic [2:0] pad_in_i,
  input wire logic [2:0] pad_out_o,
  input wire logic [2:0] pad_oe_o,
  input wire logic [2:0] pad_pullup_o,
  input wire logic [2:0] core_in_o
);
  logic [2:0] d_q, cr_q, f1_q, f2_q, pup_q;
  logic pin1_exp;
  logic pin2_exp;
  logic oe0_exp;
  // only the low three bits reach the pins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      d_q <= 3'h0;
      cr_q <= 3'h0;
      f1_q <= 3'h0;
      f2_q <= 3'h0;
      pup_q <= 3'h0;
    end else if (wr_i) begin
      case (addr_i)
        port_k_pkg::pin_data_reg_off: d_q <= wdata_i[2:0];
        port_k_pkg::output_control_reg_off: cr_q <= wdata_i[2:0];
        port_k_pkg::fn_select_one_off: f1_q <= wdata_i[2:0];
        port_k_pkg::fn_select_two_off: f2_q <= wdata_i[2:0];
        port_k_pkg::pullup_enable_off: pup_q <= wdata_i[2:0];
        default: ;
      endcase
    end
  end
  // alarm ahead of the clock output so a double select stays defined
  assign pin2_exp = f1_q[2] ? timer_nine_output_i : d_q[2];
  assign pin1_exp = f2_q[1] ? alarm_output_i :
    (f1_q[1] ? system_clock_output_i : d_q[1]);
  assign oe0_exp = f1_q[0] ? (fn_pin0_oe_i & ~fn_pin0_out_i) :
    (cr_q[0] & ~d_q[0]);

  pin2_mux_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) pad_out_o[2] == $past(pin2_exp))
    else $error("pin 2 value wrong");
  pin1_mux_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) pad_out_o[1] == $past(pin1_exp))
    else $error("pin 1 value wrong");
  pin0_drive_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) pad_oe_o[0] == $past(oe0_exp))
    else $error("pin 0 open drain enable wrong");
  pin0_fixed_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (pad_out_o[0] | pad_pullup_o[0]) == 1'b0)
    else $error("pin 0 drives high or pulls up");
  drive_en_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) pad_oe_o[2:1] == $past(cr_q[2:1]))
    else $error("output enable wrong");
  pull_en_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pad_pullup_o[2:1] == $past(pup_q[2:1]))
    else $error("pull-up enable wrong");
  pull_reset_a: assert property (
    @(posedge clk_i) !rstn_i |-> pad_pullup_o == 3'h0)
    else $error("pull-up active in reset");
  input_gate_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (core_in_o & ~$past(pad_in_i, 2)) == 3'h0)
    else $error("core input not from pad");
  read_high_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) rd_i |=> rdata_o[31:3] == 29'h0)
    else $error("upper read bits not zero");
  read_idle_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) !rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule

bind port_k_ctrl port_k_checker port_k_checker_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .timer_nine_output_i(timer_nine_output_i),
  .system_clock_output_i(system_clock_output_i),
  .alarm_output_i(alarm_output_i), .fn_pin0_out_i(fn_pin0_out_i),
  .fn_pin0_oe_i(fn_pin0_oe_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o), .core_in_o(core_in_o)
);

// >>> verif/port_k_pads.sv
`timescale 1ns/1ps
// pad wires: block driver first, then an outside driver, then the pull
module port_k_pads (
  input wire logic clk_i,
  input wire logic [2:0] pad_out_i,
  input wire logic [2:0] pad_oe_i,
  input wire logic [2:0] pad_pullup_i,
  input wire logic [2:0] ext_val_i,
  input wire logic [2:0] ext_en_i,
  output logic [2:0] level_o
);
  logic [2:0] float_q = 3'h5;
  // a floating pin wanders so a stale level cannot pass for a real one
  always @(posedge clk_i) float_q <= ~float_q;
  // pin 0 has no pull and its driver only pulls low
  assign level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
    | (~pad_oe_i & ~ext_en_i & (pad_pullup_i | float_q));
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
// registers written over the plain bus, pins judged through the pad model
module tb_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic tmr = 1'b0;
  logic sck = 1'b0;
  logic alm = 1'b0;
  logic [2:0] ext_val = 3'h0;
  logic [2:0] ext_en = 3'h0;
  logic [31:0] rdata_o;
  logic [2:0] lvl, pad_out, pad_oe, pad_pu, core_in;
  logic [7:0] offs [6] = '{port_k_pkg::pin_data_reg_off,
    port_k_pkg::output_control_reg_off, port_k_pkg::fn_select_one_off,
    port_k_pkg::fn_select_two_off, port_k_pkg::pullup_enable_off,
    port_k_pkg::input_enable_off};
  logic [31:0] full [6] = '{32'h7, 32'h7, 32'h6, 32'h2, 32'h6, 32'h7};
  int n_fail = 0;
  int n_checks = 0;

  always #25 clk_i = ~clk_i;

  port_k_ctrl port_k_ctrl_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_nine_output_i(tmr), .system_clock_output_i(sck),
    .alarm_output_i(alm), .fn_pin0_out_i(1'b0), .fn_pin0_oe_i(1'b0),
    .pad_in_i(lvl), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .pad_pullup_o(pad_pu), .core_in_o(core_in)
  );
  port_k_pads port_k_pads_inst (
    .clk_i(clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .pad_pullup_i(pad_pu), .ext_val_i(ext_val), .ext_en_i(ext_en),
    .level_o(lvl)
  );

  task automatic chk32(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk3(input string nm, input logic [2:0] e,
    input logic [2:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk32("rdata", e, rdata_o);
  endtask
  // pad output flop then pad sample flop, plus one cycle for the core input flop
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task t_reset_vals();
    for (int i = 0; i < 6; i++) rd(offs[i], 32'h0);
    chk3("pad_oe", 3'h0, pad_oe);
    chk3("pad_pullup", 3'h0, pad_pu);
    chk3("core_in", 3'h0, core_in);
    $display("test reset values done");
  endtask
  task t_regs();
    // the reserved pin 0 function is never selected, even briefly
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], (i == 2) ? 32'hffff_fffe : 32'hffff_ffff);
    end
    wr(port_k_pkg::fn_select_one_off, 32'hffff_fffe);
    wr(8'h10, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) rd(offs[i], full[i]);
    rd(8'h10, 32'h0);
    @(posedge clk_i);
    tmr <= 1'b1;
    sck <= 1'b1;
    settle();
    chk3("pad_out", 3'h4, pad_out);
    chk3("pad_oe", 3'h6, pad_oe);
    chk3("pad_pullup", 3'h6, pad_pu);
    @(posedge clk_i);
    tmr <= 1'b0;
    sck <= 1'b0;
    alm <= 1'b1;
    settle();
    chk3("pad_out", 3'h2, pad_out);
    wr(port_k_pkg::fn_select_two_off, 32'h0);
    settle();
    chk3("pad_out", 3'h0, pad_out);
    @(posedge clk_i);
    sck <= 1'b1;
    settle();
    chk3("pad_out", 3'h2, pad_out);
    wr(port_k_pkg::fn_select_one_off, 32'h0);
    settle();
    chk3("pad_out", 3'h6, pad_out);
    $display("test registers and muxing done");
  endtask
  task t_input();
    wr(port_k_pkg::output_control_reg_off, 32'h0);
    wr(port_k_pkg::pullup_enable_off, 32'h0);
    @(posedge clk_i);
    ext_en <= 3'h7;
    ext_val <= 3'h5;
    settle();
    chk3("core_in", 3'h5, core_in);
    rd(port_k_pkg::pin_data_reg_off, 32'h5);
    wr(port_k_pkg::input_enable_off, 32'h2);
    settle();
    chk3("core_in", 3'h0, core_in);
    wr(port_k_pkg::input_enable_off, 32'h7);
    wr(port_k_pkg::pullup_enable_off, 32'h6);
    @(posedge clk_i);
    ext_en <= 3'h0;
    settle();
    chk3("core_in", 3'h6, core_in & 3'h6);
    $display("test input path done");
  endtask
  task t_pin0();
    @(posedge clk_i);
    ext_en <= 3'h1;
    ext_val <= 3'h7;
    wr(port_k_pkg::pin_data_reg_off, 32'h0);
    wr(port_k_pkg::output_control_reg_off, 32'h1);
    settle();
    chk3("pad_oe", 3'h1, pad_oe);
    chk3("core_in", 3'h0, core_in & 3'h1);
    wr(port_k_pkg::pin_data_reg_off, 32'h1);
    settle();
    chk3("pad_oe", 3'h0, pad_oe);
    chk3("core_in", 3'h1, core_in & 3'h1);
    $display("test open drain done");
  endtask
  task t_midreset();
    chk3("pad_pullup", 3'h6, pad_pu);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(posedge clk_i);
    #1 chk3("pad_pullup", 3'h0, pad_pu);
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset_vals();
    $display("test reset in mid-run done");
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset_vals();
    t_regs();
    t_input();
    t_pin0();
    t_midreset();
    test_done();
  end
  initial begin
    #(2000 * 50);
    n_fail++;
    test_done();
  end
endmodule
